// ### design/pulse_period_timer.sv
// one pulse per period with selectable high width
`timescale 1ns/1ps
`default_nettype none
module pulse_period_timer #(
  parameter int unsigned W = 32
) (
  // clock and reset
  input  wire  logic         core_clk,
  input  wire  logic         rst_b,
  // control
  input  wire  logic         run,
  input  wire  logic         quarter,
  input  wire  logic [W-1:0] period,
  // pulse
  output logic               level,
  output logic               start,
  output logic               active
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] hi_r;
  logic         level_r;
  wire  [W-1:0] hi_w = quarter ? (period >> 2) : (period >> 1);
  assign start  = run & (cnt_r == '0);
  assign active = (cnt_r != '0);
  assign level  = level_r;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_r   <= '0;
      hi_r    <= '0;
      level_r <= 1'b0;
    end else if (start) begin
      cnt_r   <= period - 1'b1;
      hi_r    <= hi_w - 1'b1;
      level_r <= 1'b1;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
      if (hi_r == '0) begin
        level_r <= 1'b0;
      end else begin
        hi_r <= hi_r - 1'b1;
      end
    end else begin
      level_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### design/restoring_divider.sv
// sequential unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module restoring_divider #(
  parameter int unsigned W = 32
) (
  // clock and reset
  input  wire  logic         core_clk,
  input  wire  logic         rst_b,
  // request
  input  wire  logic         go,
  input  wire  logic [W-1:0] num,
  input  wire  logic [W-1:0] den,
  // answer
  output logic               busy,
  output logic               done,
  output logic [W-1:0]       quo
);
  localparam int unsigned NW = $clog2(W + 1);
  logic [W-1:0]  rem_r;
  logic [W-1:0]  q_r;
  logic [W-1:0]  d_r;
  logic [NW-1:0] n_r;
  logic          busy_r;
  logic          done_r;
  wire  [W:0]    sh   = {rem_r, q_r[W-1]};
  wire  [W:0]    diff = sh - {1'b0, d_r};
  wire           fits = (sh >= {1'b0, d_r});
  assign busy = busy_r;
  assign done = done_r;
  assign quo  = q_r;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rem_r  <= '0;
      q_r    <= '0;
      d_r    <= '0;
      n_r    <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (go && !busy_r) begin
        q_r    <= num;
        d_r    <= den;
        rem_r  <= '0;
        n_r    <= NW'(W);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        rem_r <= fits ? diff[W-1:0] : sh[W-1:0];
        q_r   <= {q_r[W-2:0], fits};
        n_r   <= n_r - 1'b1;
        if (n_r == NW'(1)) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### design/tpp_pkg.sv
// constants and types shared by the trapezoidal pulse positioner
package tpp_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam logic [14:0] MS_LAST    = 15'(CYC_PER_MS - 1);
  localparam logic [31:0] CLK_HZ_W   = 32'(CLK_HZ);
  localparam logic [31:0] SLOW_NUM   = 32'(2 * CLK_HZ);
  localparam logic [31:0] SLOW_DEN   = 32'h3;
  // bus
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  // register byte offsets
  localparam logic [7:0]  A_PCTRL    = 8'h00;
  localparam logic [7:0]  A_CNT_LO   = 8'h04;
  localparam logic [7:0]  A_CNT_HI   = 8'h08;
  localparam logic [7:0]  A_HOLD0    = 8'h0c;
  localparam logic [7:0]  A_HOLD2    = 8'h10;
  localparam logic [7:0]  A_TCTRL    = 8'h14;
  localparam logic [7:0]  A_FINIT    = 8'h18;
  localparam logic [7:0]  A_FMAX     = 8'h1c;
  localparam logic [7:0]  A_RAMP     = 8'h20;
  localparam logic [7:0]  A_TGT      = 8'h24;
  localparam logic [7:0]  A_START    = 8'h28;
  localparam logic [7:0]  A_STAT     = 8'h2c;
  localparam logic [7:0]  A_NONE     = 8'hff;
  // pulse control word fields
  localparam int unsigned CHAN_BIT   = 13;
  localparam int unsigned STOP_BIT   = 3;
  localparam int unsigned CRST_BIT   = 0;
  // table control word digit positions
  localparam int unsigned TC_FIX_LSB  = 20;
  localparam int unsigned TC_STEP_LSB = 16;
  localparam int unsigned TC_DUTY_LSB = 12;
  localparam int unsigned TC_RNG_LSB  = 8;
  localparam int unsigned TC_MHI_LSB  = 4;
  localparam int unsigned TC_MLO_LSB  = 0;
  // ramp and speed limits
  localparam logic [5:0]  STEPS_30   = 6'h1e;
  localparam logic [5:0]  STEPS_60   = 6'h3c;
  localparam logic [15:0] RAMP_MAX   = 16'h7ff8;
  localparam logic [31:0] R0_MIN     = 32'h1;
  localparam logic [31:0] R0_MAX     = 32'h2648;
  localparam logic [31:0] R1_MIN     = 32'h30;
  localparam logic [31:0] R2_MIN     = 32'hbf;
  localparam logic [31:0] RH_MAX     = 32'h186a0;
  // mode digits
  localparam logic [3:0]  MLO_CWCCW  = 4'h0;
  localparam logic [3:0]  MLO_DIR_LO = 4'h2;
  localparam logic [3:0]  MLO_DIR_HI = 4'h3;
  localparam logic [3:0]  MHI_ABS    = 4'h1;
  // reset values
  localparam logic [15:0] HALF_RST   = 16'h0000;
  localparam logic [23:0] TCTRL_RST  = 24'h000000;
  localparam logic [31:0] WORD_RST   = 32'h00000000;
  typedef enum logic [2:0] {ST_IDLE, ST_STEP, ST_DELTA, ST_PER, ST_RUN, ST_DRAIN} pos_state_t;
endpackage

// ### design/trapezoidal_pulse_positioner.sv
// trapezoidal pulse positioner with ahb-lite register slave
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module trapezoidal_pulse_positioner (
  // clock and reset
  input  wire  logic        core_clk,
  input  wire  logic        rst_b,
  // ahb-lite slave
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // motor driver
  output logic              pulse_a,
  output logic              pulse_b,
  output logic              busy
);
  import tpp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // bus front end
  logic        wr_r;
  logic [7:0]  addr_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  logic        hresp_r;
  wire         ap_take = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
  wire         ap_ok   = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'h0);
  wire  [7:0]  ap_addr = ap_ok ? haddr[7:0] : A_NONE;
  wire         rd_take = ap_take & ~hwrite;
  wire         w_pctrl = wr_r & (addr_r == A_PCTRL);
  wire         w_cnt_lo = wr_r & (addr_r == A_CNT_LO);
  wire         w_cnt_hi = wr_r & (addr_r == A_CNT_HI);
  wire         w_tctrl = wr_r & (addr_r == A_TCTRL);
  wire         w_finit = wr_r & (addr_r == A_FINIT);
  wire         w_fmax  = wr_r & (addr_r == A_FMAX);
  wire         w_ramp  = wr_r & (addr_r == A_RAMP);
  wire         w_tgt   = wr_r & (addr_r == A_TGT);
  wire         w_start = wr_r & (addr_r == A_START) & hwdata[0];

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wr_r   <= 1'b0;
      addr_r <= A_NONE;
    end else begin
      wr_r   <= ap_take & hwrite;
      addr_r <= ap_take ? ap_addr : A_NONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software registers
  logic [15:0] pctrl_r;
  logic [15:0] hold0_r;
  logic [15:0] hold2_r;
  logic [23:0] tctrl_r;
  logic [31:0] finit_r;
  logic [31:0] fmax_r;
  logic [15:0] ramp_r;
  logic [31:0] tgt_r;
  logic [15:0] cnt_stash_r;
  logic [15:0] cnt_snap_r;
  logic [31:0] cnt_r;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pctrl_r <= HALF_RST;
      hold0_r <= HALF_RST;
      hold2_r <= HALF_RST;
    end else if (w_pctrl) begin
      pctrl_r <= hwdata[15:0];
      if (hwdata[CHAN_BIT]) begin
        hold2_r <= hwdata[15:0];
      end else begin
        hold0_r <= hwdata[15:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tctrl_r <= TCTRL_RST;
      finit_r <= WORD_RST;
      fmax_r  <= WORD_RST;
      ramp_r  <= HALF_RST;
      tgt_r   <= WORD_RST;
    end else begin
      if (w_tctrl) tctrl_r <= hwdata[23:0];
      if (w_finit) finit_r <= hwdata;
      if (w_fmax) fmax_r <= hwdata;
      if (w_ramp) ramp_r <= hwdata[15:0];
      if (w_tgt) tgt_r <= hwdata;
    end
  end

  // low half written first is held until the high half commits both
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_stash_r <= HALF_RST;
      cnt_snap_r  <= HALF_RST;
    end else begin
      if (w_cnt_lo) cnt_stash_r <= hwdata[15:0];
      if (rd_take && ap_addr == A_CNT_LO) cnt_snap_r <= cnt_r[31:16];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // table decode
  wire  [3:0]  t_fix  = tctrl_r[TC_FIX_LSB +: 4];
  wire  [3:0]  t_step = tctrl_r[TC_STEP_LSB +: 4];
  wire  [3:0]  t_duty = tctrl_r[TC_DUTY_LSB +: 4];
  wire  [3:0]  t_rng  = tctrl_r[TC_RNG_LSB +: 4];
  wire  [3:0]  t_mhi  = tctrl_r[TC_MHI_LSB +: 4];
  wire  [3:0]  t_mlo  = tctrl_r[TC_MLO_LSB +: 4];
  wire         t_mlo_ok = (t_mlo == MLO_CWCCW) || (t_mlo == MLO_DIR_LO) || (t_mlo == MLO_DIR_HI);
  wire         t_ok   = (t_fix == 4'h0) && (t_step <= 4'h1) && (t_duty <= 4'h1) && (t_rng <= 4'h2)
                        && (t_mhi <= MHI_ABS) && t_mlo_ok;

  function automatic logic [31:0] clamp_hz(input logic [31:0] f, input logic [1:0] rng);
    logic [31:0] lo;
    logic [31:0] hi;
    lo = (rng == 2'h0) ? R0_MIN : (rng == 2'h1) ? R1_MIN : R2_MIN;
    hi = (rng == 2'h0) ? R0_MAX : RH_MAX;
    return (f < lo) ? lo : ((f > hi) ? hi : f);
  endfunction

  wire  [31:0] f0_c   = clamp_hz(finit_r, t_rng[1:0]);
  wire  [31:0] fm_raw = clamp_hz(fmax_r, t_rng[1:0]);
  wire  [31:0] fm_c   = (fm_raw < f0_c) ? f0_c : fm_raw;
  wire         t_abs  = (t_mhi == MHI_ABS);
  wire  [32:0] dist_s = {tgt_r[31], tgt_r} - (t_abs ? {cnt_r[31], cnt_r} : 33'h0);
  wire  [32:0] dist_m = dist_s[32] ? (33'h0 - dist_s) : dist_s;

  //////////////////////////////////////////////////////////////////////////////
  // profile state
  pos_state_t  state_r;
  pos_state_t  state_nxt;
  logic [23:0] run_ctrl_r;
  logic [31:0] f0_r;
  logic [31:0] fm_r;
  logic [31:0] spd_r;
  logic [31:0] delta_r;
  logic [31:0] per_r;
  logic [31:0] rem_r;
  logic [31:0] acc_pul_r;
  logic [15:0] step_ms_r;
  logic [15:0] ms_in_step_r;
  logic [14:0] ms_pre_r;
  logic [5:0]  k_r;
  logic        rev_r;
  logic        per_req_r;
  logic        div_busy;
  logic        div_done;
  logic [31:0] div_quo;
  logic        tmr_level;
  logic        tmr_start;
  logic        tmr_active;

  wire  [5:0]  r_n     = run_ctrl_r[TC_STEP_LSB] ? STEPS_60 : STEPS_30;
  wire         r_quart = run_ctrl_r[TC_DUTY_LSB];
  wire  [1:0]  r_rng   = run_ctrl_r[TC_RNG_LSB +: 2];
  wire  [3:0]  r_mlo   = run_ctrl_r[TC_MLO_LSB +: 4];
  wire  [15:0] r_n16   = {10'h0, r_n};
  wire  [15:0] ramp_c  = (ramp_r > RAMP_MAX) ? RAMP_MAX : ((ramp_r < r_n16) ? r_n16 : ramp_r);
  wire         stop    = hold0_r[STOP_BIT];
  wire         slow    = (r_rng == 2'h0) && (spd_r == R0_MIN);
  wire         in_calc = (state_r == ST_STEP) || (state_r == ST_DELTA) || (state_r == ST_PER);
  wire         in_run  = (state_r == ST_RUN);
  wire         ramp_op = (state_r == ST_STEP) || (state_r == ST_DELTA);
  wire  [31:0] div_num = (state_r == ST_STEP) ? ({16'h0, ramp_c} + {26'h0, r_n} - 32'h1) :
                         (state_r == ST_DELTA) ? (fm_r - f0_r) :
                         (slow ? SLOW_NUM : CLK_HZ_W);
  wire  [31:0] div_den = ramp_op ? {26'h0, r_n} : (slow ? SLOW_DEN : spd_r);
  wire         div_free = ~div_busy & ~div_done;
  wire         div_go  = in_calc ? div_free : (in_run & per_req_r & div_free);
  wire         tmr_run = in_run & (rem_r != 32'h0) & ~stop;
  wire         ms_tick = in_run & (ms_pre_r == MS_LAST);
  wire         step_tick = ms_tick & (ms_in_step_r == (step_ms_r - 16'h1));
  wire         dec_now = (rem_r <= acc_pul_r);
  wire         at_top  = (k_r == r_n);
  wire         take_start = (state_r == ST_IDLE) && w_start && t_ok && !stop;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:  if (take_start) state_nxt = ST_STEP;
      ST_STEP:  if (div_done) state_nxt = ST_DELTA;
      ST_DELTA: if (div_done) state_nxt = ST_PER;
      ST_PER:   if (div_done) state_nxt = ST_RUN;
      ST_RUN:   if (stop) state_nxt = ST_IDLE;
                else if (rem_r == 32'h0) state_nxt = ST_DRAIN;
      ST_DRAIN: if (!tmr_active) state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_r    <= ST_IDLE;
      run_ctrl_r <= TCTRL_RST;
      f0_r       <= WORD_RST;
      fm_r       <= WORD_RST;
      rev_r      <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (take_start) begin
        run_ctrl_r <= tctrl_r;
        f0_r       <= f0_c;
        fm_r       <= fm_c;
        rev_r      <= dist_s[32];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      step_ms_r <= HALF_RST;
      delta_r   <= WORD_RST;
      per_r     <= WORD_RST;
    end else if (div_done) begin
      if (state_r == ST_STEP) step_ms_r <= div_quo[15:0];
      if (state_r == ST_DELTA) delta_r <= div_quo;
      if (state_r == ST_PER || in_run) per_r <= div_quo;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || !in_run) begin
      ms_pre_r     <= 15'h0;
      ms_in_step_r <= HALF_RST;
    end else begin
      ms_pre_r <= ms_tick ? 15'h0 : (ms_pre_r + 15'h1);
      if (step_tick) ms_in_step_r <= HALF_RST;
      else if (ms_tick) ms_in_step_r <= ms_in_step_r + 16'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rem_r     <= WORD_RST;
      acc_pul_r <= WORD_RST;
    end else if (take_start) begin
      rem_r     <= dist_m[31:0];
      acc_pul_r <= WORD_RST;
    end else if (tmr_start) begin
      rem_r <= rem_r - 32'h1;
      if (!dec_now && !at_top) acc_pul_r <= acc_pul_r + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      k_r       <= 6'h0;
      spd_r     <= WORD_RST;
      per_req_r <= 1'b0;
    end else if (take_start) begin
      k_r       <= 6'h0;
      spd_r     <= f0_c;
      per_req_r <= 1'b0;
    end else begin
      if (div_go && in_run) per_req_r <= 1'b0;
      if (step_tick && dec_now && k_r != 6'h0) begin
        k_r       <= k_r - 6'h1;
        spd_r     <= (k_r == 6'h1) ? f0_r : (spd_r - delta_r);
        per_req_r <= 1'b1;
      end else if (step_tick && !dec_now && !at_top) begin
        k_r       <= k_r + 6'h1;
        spd_r     <= ((k_r + 6'h1) == r_n) ? fm_r : (spd_r + delta_r);
        per_req_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_r <= WORD_RST;
    end else if (hold0_r[CRST_BIT]) begin
      cnt_r <= WORD_RST;
    end else if (w_cnt_hi) begin
      cnt_r <= {hwdata[15:0], cnt_stash_r};
    end else if (tmr_start) begin
      cnt_r <= rev_r ? (cnt_r - 32'h1) : (cnt_r + 32'h1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  restoring_divider #(
    .W        (32)
  ) u_div (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .go       (div_go),
    .num      (div_num),
    .den      (div_den),
    .busy     (div_busy),
    .done     (div_done),
    .quo      (div_quo)
  );

  pulse_period_timer #(
    .W        (32)
  ) u_tmr (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .run      (tmr_run),
    .quarter  (r_quart),
    .period   (per_r),
    .level    (tmr_level),
    .start    (tmr_start),
    .active   (tmr_active)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs and read data
  logic        pulse_a_r;
  logic        pulse_b_r;
  logic        busy_r;
  wire         cwccw  = (r_mlo == MLO_CWCCW);
  wire         pa_nxt = cwccw ? (tmr_level & ~rev_r) : tmr_level;
  wire         pb_nxt = cwccw ? (tmr_level & rev_r) : ((r_mlo == MLO_DIR_LO) ? rev_r : ~rev_r);
  wire  [31:0] stat_w = {18'h0, k_r, 5'h0, in_run, rev_r, busy_r};
  wire  [31:0] rd_mux = (ap_addr == A_PCTRL)  ? {16'h0, pctrl_r} :
                        (ap_addr == A_CNT_LO) ? {16'h0, cnt_r[15:0]} :
                        (ap_addr == A_CNT_HI) ? {16'h0, cnt_snap_r} :
                        (ap_addr == A_HOLD0)  ? {16'h0, hold0_r} :
                        (ap_addr == A_HOLD2)  ? {16'h0, hold2_r} :
                        (ap_addr == A_TCTRL)  ? {8'h0, tctrl_r} :
                        (ap_addr == A_FINIT)  ? finit_r :
                        (ap_addr == A_FMAX)   ? fmax_r :
                        (ap_addr == A_RAMP)   ? {16'h0, ramp_r} :
                        (ap_addr == A_TGT)    ? tgt_r :
                        (ap_addr == A_STAT)   ? stat_w : 32'h0;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pulse_a_r <= 1'b0;
      pulse_b_r <= 1'b0;
      busy_r    <= 1'b0;
      hrdata_r  <= WORD_RST;
    end else begin
      pulse_a_r <= pa_nxt;
      pulse_b_r <= pb_nxt;
      busy_r    <= (state_r != ST_IDLE) || tmr_active;
      hrdata_r  <= rd_take ? rd_mux : WORD_RST;
    end
  end

  assign pulse_a   = pulse_a_r;
  assign pulse_b   = pulse_b_r;
  assign busy      = busy_r;
  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;
endmodule
`default_nettype wire

// ### dv/motor_driver_model.sv
// motor driver model: counts forward and reverse steps, measures high width
`timescale 1ns/1ps
`default_nettype none
module motor_driver_model (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        pulse_a,
  input  wire logic        pulse_b,
  input  wire logic        dir_style,
  input  wire logic        fwd_high,
  output int               fwd_n,
  output int               rev_n,
  output logic [31:0]      hi_w
);
  logic        a_q;
  logic        b_q;
  logic [31:0] run_w;
  logic        w_q;
  wire  logic  pw = dir_style ? pulse_a : (pulse_a | pulse_b);
  always @(posedge core_clk) begin
    a_q <= pulse_a;
    b_q <= pulse_b;
    w_q <= pw;
    if (!rst_b) begin
      fwd_n <= 0;
      rev_n <= 0;
      hi_w <= 32'h0;
      run_w <= 32'h0;
    end else begin
      if (pw) run_w <= run_w + 32'h1;
      if (w_q && !pw) begin
        hi_w <= run_w;
        run_w <= 32'h0;
      end
      if (pulse_a && !a_q && (!dir_style || pulse_b == fwd_high)) fwd_n <= fwd_n + 1;
      if (pulse_a && !a_q && dir_style && pulse_b != fwd_high) rev_n <= rev_n + 1;
      if (!dir_style && pulse_b && !b_q) rev_n <= rev_n + 1;
    end
  end
endmodule
`default_nettype wire

// ### dv/tpp_chk.sv
// port assertions for the trapezoidal pulse positioner
`timescale 1ns/1ps
`default_nettype none
module tpp_chk
  import tpp_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // motor
  input wire logic        pulse_a,
  input wire logic        pulse_b,
  input wire logic        busy
);
  logic rd_dp_r;
  logic start_dp_r;
  wire  taken = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
  wire  to_start = haddr == {24'h0, A_START};
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rd_dp_r <= 1'b0;
      start_dp_r <= 1'b0;
    end else begin
      rd_dp_r <= taken && !hwrite;
      start_dp_r <= taken && hwrite && to_start;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_start_land;
    $past(start_dp_r && hwdata[0], 2);
  endsequence
  sequence s_quiet;
    !pulse_a [*8];
  endsequence
  AST_HREADY: assert property (hreadyout) else $error("hreadyout low");
  AST_OKAY: assert property (!hresp) else $error("hresp not okay");
  AST_RDATA_IDLE: assert property (!rd_dp_r |-> hrdata == 32'h0) else $error("hrdata outside read");
  AST_BUSY_START: assert property ($rose(busy) |-> s_start_land) else $error("busy without start");
  AST_FIRST_QUIET: assert property ($rose(busy) |-> s_quiet) else $error("pulse too soon");
  AST_HIGH_WIDTH: assert property ($rose(pulse_a) |-> pulse_a [*8]) else $error("pulse too short");
  AST_DIR_STABLE: assert property (pulse_a && $past(pulse_a) |-> $stable(pulse_b)) else $error("dir moved");
  AST_IDLE_QUIET: assert property (!busy |-> !pulse_a) else $error("pulse while idle");
  cover property ($fell(busy));
endmodule
bind trapezoidal_pulse_positioner tpp_chk chk (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pulse_a(pulse_a), .pulse_b(pulse_b), .busy(busy));
`default_nettype wire

// ### dv/trapezoidal_pulse_positioner_tb.sv
// self-checking bench for the trapezoidal pulse positioner
`timescale 1ns/1ps
`default_nettype none
module trapezoidal_pulse_positioner_tb;
  import tpp_pkg::*;
  logic core_clk, rst_b, hsel, hwrite, dir_style, fwd_high, neg;
  logic [31:0] haddr, hwdata, p, t, e, c, hi_w;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] lf_r;
  wire  logic hreadyout, hresp, pulse_a, pulse_b, busy;
  wire  logic [31:0] hrdata;
  int   err_total, comparisons, f0, r0, mag, f0_n, r0_n;
  logic [7:0] rst_regs [5] = '{A_PCTRL, A_CNT_LO, A_HOLD0, A_TCTRL, A_STAT};
  logic [7:0] modes [3] = '{8'h00, 8'h02, 8'h13};
  trapezoidal_pulse_positioner DUT (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pulse_a(pulse_a), .pulse_b(pulse_b), .busy(busy));
  motor_driver_model drv (.core_clk(core_clk), .rst_b(rst_b), .pulse_a(pulse_a), .pulse_b(pulse_b),
    .dir_style(dir_style), .fwd_high(fwd_high), .fwd_n(f0_n), .rev_n(r0_n), .hi_w(hi_w));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] exp_hi(input int unsigned f);
    return 32'((CLK_HZ / f) / 4);
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wait_until(input logic lv, input int lim);
    int n;
    n = 0;
    while (busy !== lv) begin
      n++;
      if (n > lim) begin
        err_total++;
        report_and_stop();
      end
      @(posedge core_clk);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        err_total++;
        report_and_stop();
      end
      @(posedge core_clk);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    wait_rdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    check(r, want);
  endtask
  task automatic set_cnt(input logic [31:0] v);
    wr(A_CNT_LO, {16'h0, v[15:0]});
    wr(A_CNT_HI, {16'h0, v[31:16]});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    {hsel, hwrite, dir_style, fwd_high, rst_b} = 5'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = HSIZE_WORD;
    lf_r = 16'h0037;
    err_total = 0;
    comparisons = 0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (rst_regs[i]) rd(rst_regs[i], 32'h0);
    wr(A_NONE, 32'hffffffff);
    rd(A_NONE, 32'h0);
    $display("test reset and unmapped done");
    wr(A_PCTRL, 32'h2008);
    rd(A_HOLD2, 32'h2008);
    rd(A_HOLD0, 32'h0);
    wr(A_PCTRL, 32'h0001);
    rd(A_HOLD0, 32'h0001);
    rd(A_HOLD2, 32'h2008);
    set_cnt(32'h12345678);
    rd(A_CNT_LO, 32'h0);
    wr(A_PCTRL, 32'h0);
    $display("test holding words done");
    for (int i = 0; i < 3; i++) begin
      lf_r = lfsr_next(lf_r);
      p[31:16] = lf_r;
      lf_r = lfsr_next(lf_r);
      p[15:0] = lf_r;
      set_cnt(p);
      rd(A_CNT_LO, {16'h0, p[15:0]});
      rd(A_CNT_HI, {16'h0, p[31:16]});
    end
    $display("test count preset done");
    wr(A_TCTRL, 32'h001001);
    wr(A_START, 32'h1);
    repeat (4) @(posedge core_clk);
    check({31'h0, busy}, 32'h0);
    rd(A_STAT, 32'h0);
    $display("test refused start done");
    foreach (modes[i]) begin
      dir_style <= modes[i][3:0] != MLO_CWCCW;
      fwd_high <= modes[i][3:0] == MLO_DIR_HI;
      lf_r = lfsr_next(lf_r);
      mag = int'(lf_r[1:0]) + 1;
      neg = (i == 1) || lf_r[2];
      p = {16'h0, lf_r};
      t = (modes[i][7:4] == MHI_ABS) ? (neg ? p - 32'(mag) : p + 32'(mag)) : (neg ? -32'(mag) : 32'(mag));
      e = (modes[i][7:4] == MHI_ABS) ? t : p + t;
      set_cnt(p);
      c = {15'h0, i == 2, 4'h1, 4'(i), modes[i]};
      wr(A_TCTRL, c);
      wr(A_FINIT, 32'd9800);
      wr(A_FMAX, 32'd9800);
      wr(A_RAMP, 32'd30);
      wr(A_TGT, t);
      rd(A_TCTRL, c);
      f0 = f0_n;
      r0 = r0_n;
      wr(A_START, 32'h1);
      wait_until(1'b1, 10);
      wait_until(1'b0, 60000);
      repeat (2) @(posedge core_clk);
      check(32'(f0_n - f0), neg ? 32'h0 : 32'(mag));
      check(32'(r0_n - r0), neg ? 32'(mag) : 32'h0);
      check(hi_w, exp_hi(9800));
      rd(A_CNT_LO, {16'h0, e[15:0]});
      rd(A_CNT_HI, {16'h0, e[31:16]});
      $display("test move mode %h done", modes[i]);
    end
    set_cnt(32'h0);
    wr(A_TCTRL, 32'h001013);
    wr(A_FINIT, 32'd5000);
    wr(A_FMAX, 32'd9800);
    wr(A_TGT, 32'd40);
    f0 = f0_n;
    wr(A_START, 32'h1);
    wait_until(1'b1, 10);
    repeat (30000) @(posedge core_clk);
    rd(A_STAT, 32'h105);
    wr(A_PCTRL, 32'h8);
    wait_until(1'b0, 10000);
    repeat (2) @(posedge core_clk);
    check(32'(f0_n - f0 < 40), 32'h1);
    rd(A_CNT_LO, 32'(f0_n - f0));
    wr(A_START, 32'h1);
    repeat (4) @(posedge core_clk);
    check({31'h0, busy}, 32'h0);
    wr(A_PCTRL, 32'h0);
    set_cnt(32'h0);
    rd(A_CNT_LO, 32'h0);
    $display("test ramp step and stop done");
    report_and_stop();
  end
endmodule
`default_nettype wire
